// ===== hdl/urx_cfg.svh
`ifndef URX_CFG_SVH
`define URX_CFG_SVH

// Halfword register indices on host_reg_addr[7:1]
`define URX_IDX_STATUS      7'h00
`define URX_IDX_CTRL        7'h01
`define URX_IDX_COUNT       7'h02
`define URX_IDX_EP_PORT     7'h10

// Status fields
`define URX_ST_PENDING      0
`define URX_ST_OVERFLOW     1
`define URX_ST_ERROR        2
`define URX_ST_HEAD_ODD     3

// Control fields and reset value
`define URX_CT_RX_EN        0
`define URX_CTRL_RESET      16'h0001

// Receive link geometry
`define URX_WORD_W          16
`define URX_FIFO_DEPTH      32
`define URX_LINK_RATE_MHZ   30

`endif

// ===== hdl/urx_pkg.sv
package urx_pkg;

  typedef enum logic [1:0] {
    URX_IDLE = 2'b00,
    URX_ACK  = 2'b01,
    URX_HOLD = 2'b10
  } urx_host_state_e;

  typedef struct packed {
    logic        odd;
    logic [15:0] data;
  } urx_word_s;

endpackage

// ===== hdl/urx_fifo_if.sv
`timescale 1ns/1ps
interface urx_fifo_if #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 32
);
  logic [WIDTH-1:0]         in_data;
  logic                     in_valid;
  logic                     in_ready;
  logic                     commit;
  logic                     discard;
  logic [WIDTH-1:0]         out_data;
  logic                     out_valid;
  logic                     out_ready;
  logic [$clog2(DEPTH):0]   out_count;

  modport fifo (input in_data, in_valid, commit, discard, out_ready,
                output in_ready, out_data, out_valid, out_count);
  modport user (output in_data, in_valid, commit, discard, out_ready,
                input in_ready, out_data, out_valid, out_count);
endinterface // urx_fifo_if

// ===== hdl/urx_fifo.sv
`timescale 1ns/1ps
// Packet FIFO: writes stay hidden from the drain side until committed,
// and a discard rolls the write pointer back to the last commit.
module urx_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 32
) (
  input  wire logic clk_in,
  input  wire logic rst_in,
  urx_fifo_if.fifo  f
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      cm_q;
  logic [AW:0]      rd_q;
  logic             push;
  logic             pop;

  assign f.in_ready  = (wr_q - rd_q) != (AW+1)'(DEPTH);
  assign f.out_valid = cm_q != rd_q;
  assign f.out_count = cm_q - rd_q;
  assign f.out_data  = mem[rd_q[AW-1:0]];
  assign push        = f.in_valid && f.in_ready && !f.discard;
  assign pop         = f.out_valid && f.out_ready;

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_q[AW-1:0]] <= f.in_data;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wr_q <= '0;
      cm_q <= '0;
    end else if (f.discard) begin
      wr_q <= cm_q;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (f.commit) begin
        cm_q <= push ? wr_q + 1'b1 : wr_q;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rd_q <= '0;
    end else if (pop) begin
      rd_q <= rd_q + 1'b1;
    end
  end
endmodule // urx_fifo

// ===== hdl/urx_top.sv
`timescale 1ns/1ps
`include "urx_cfg.svh"
module urx_top (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic [15:0] rx_data_in,
  input  wire logic [1:0]  rx_valid_in,
  input  wire logic        rx_active_in,
  input  wire logic        rx_error_in,
  input  wire logic        host_req_valid_in,
  input  wire logic [7:1]  host_reg_addr_in,
  input  wire logic        host_read_sel_in,
  input  wire logic [1:0]  host_byte_lane_en_in,
  input  wire logic [15:0] host_write_word_in,
  output logic             host_access_ack_out,
  output logic [15:0]      host_read_word_out,
  output logic             pkt_pending_out,
  output logic             rx_overflow_out
);
  localparam int FW = $bits(urx_pkg::urx_word_s);

  urx_fifo_if #(.WIDTH(FW), .DEPTH(`URX_FIFO_DEPTH)) fq ();

  urx_fifo #(.WIDTH(FW), .DEPTH(`URX_FIFO_DEPTH)) u_fifo (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .f      (fq)
  );

  urx_pkg::urx_host_state_e st_q;
  urx_pkg::urx_word_s       in_w;
  urx_pkg::urx_word_s       head_w;
  logic [15:0] ctrl_q;
  logic [15:0] rd_q;
  logic [15:0] status;
  logic [15:0] rd_d;
  logic [15:0] lane_mask;
  logic        active_q;
  logic        in_pkt_q;
  logic        drop_q;
  logic        ovf_q;
  logic        err_q;
  logic        pkt_on;
  logic        take;
  logic        rd_take;
  logic        ctrl_wr;
  logic        pkt_end;
  logic        ovf_ev;
  logic        wr_acc;
  logic        st_clr;

  // packet opens on rising active when enabled
  assign pkt_on  = in_pkt_q || (rx_active_in && !active_q && ctrl_q[`URX_CT_RX_EN]);
  // word taken only with active and valid
  assign take    = pkt_on && rx_active_in && (rx_valid_in != 2'b00);
  assign pkt_end = in_pkt_q && !rx_active_in;
  // Overflow flagged once, later words already dropped
  assign ovf_ev  = take && !fq.in_ready && !drop_q;

  // one 16-bit link word per entry
  // odd last byte flagged in the word
  assign in_w    = {rx_valid_in == 2'b01, rx_data_in};
  assign head_w  = fq.out_data;

  assign fq.in_data  = in_w;
  // Once a packet is poisoned its later words never reach the FIFO
  assign fq.in_valid = take && !drop_q && !rx_error_in;
  assign fq.discard  = pkt_end && (drop_q || rx_error_in);
  // Commit on falling active, host sees whole packets
  assign fq.commit   = pkt_end && !drop_q && !rx_error_in;

  // Packet window follows rx_active, enable taken at open
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      active_q <= 1'b0;
      in_pkt_q <= 1'b0;
    end else begin
      active_q <= rx_active_in;
      if (rx_active_in && !active_q) begin
        in_pkt_q <= ctrl_q[`URX_CT_RX_EN];
      end else if (!rx_active_in) begin
        in_pkt_q <= 1'b0;
      end
    end
  end

  // error or overflow poisons the packet
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      drop_q <= 1'b0;
    end else if (!rx_active_in) begin
      drop_q <= 1'b0;
    end else if (pkt_on && (rx_error_in || ovf_ev)) begin
      drop_q <= 1'b1;
    end
  end

  // Host port state
  assign wr_acc    = (st_q == urx_pkg::URX_ACK) && !host_read_sel_in;
  assign rd_take   = (st_q == urx_pkg::URX_IDLE) && host_req_valid_in && host_read_sel_in;
  assign ctrl_wr   = wr_acc && (host_reg_addr_in == `URX_IDX_CTRL);
  assign lane_mask = {{8{host_byte_lane_en_in[1]}}, {8{host_byte_lane_en_in[0]}}};
  // Overflow and error status bits are write-one-to-clear on lane 0
  assign st_clr    = wr_acc && (host_reg_addr_in == `URX_IDX_STATUS);

  // Sticky flags, set wins over clear
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ovf_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      if (ovf_ev) begin
        ovf_q <= 1'b1;
      end else if (st_clr && host_byte_lane_en_in[0] &&
                   host_write_word_in[`URX_ST_OVERFLOW]) begin
        ovf_q <= 1'b0;
      end
      if (pkt_on && rx_error_in) begin
        err_q <= 1'b1;
      end else if (st_clr && host_byte_lane_en_in[0] &&
                   host_write_word_in[`URX_ST_ERROR]) begin
        err_q <= 1'b0;
      end
    end
  end

  // Status word: pending, overflow, error, odd head
  always_comb begin
    status                   = 16'h0000;
    status[`URX_ST_PENDING]  = fq.out_valid;
    status[`URX_ST_OVERFLOW] = ovf_q;
    status[`URX_ST_ERROR]    = err_q;
    status[`URX_ST_HEAD_ODD] = fq.out_valid && head_w.odd;
  end

  // Read mux, unmapped indices read as zero
  always_comb begin
    case (host_reg_addr_in)
      `URX_IDX_STATUS:   rd_d = status;
      `URX_IDX_CTRL:     rd_d = ctrl_q;
      `URX_IDX_COUNT:    rd_d = 16'(fq.out_count);
      `URX_IDX_EP_PORT:  rd_d = fq.out_valid ? head_w.data : 16'h0000;
      default:           rd_d = 16'h0000;
    endcase
  end

  // single ack, then wait for request low
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_q <= urx_pkg::URX_IDLE;
    end else begin
      case (st_q)
        urx_pkg::URX_IDLE: begin
          if (host_req_valid_in) begin
            st_q <= urx_pkg::URX_ACK;
          end
        end
        urx_pkg::URX_ACK:  st_q <= urx_pkg::URX_HOLD;
        urx_pkg::URX_HOLD: begin
          if (!host_req_valid_in) begin
            st_q <= urx_pkg::URX_IDLE;
          end
        end
        default: st_q <= urx_pkg::URX_IDLE;
      endcase
    end
  end

  // read data loaded as ack rises
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rd_q <= 16'h0000;
    end else if (rd_take) begin
      rd_q <= rd_d & lane_mask;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ctrl_q <= `URX_CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl_q <= (ctrl_q & ~lane_mask) | (host_write_word_in & lane_mask);
    end
  end

  // FIFO pops one word on lane 0 reads of URX_IDX_EP_PORT
  assign fq.out_ready = (st_q == urx_pkg::URX_ACK) && host_read_sel_in &&
                        host_byte_lane_en_in[0] &&
                        (host_reg_addr_in == `URX_IDX_EP_PORT);

  assign host_access_ack_out = (st_q == urx_pkg::URX_ACK);
  assign host_read_word_out  = rd_q;
  assign pkt_pending_out     = fq.out_valid;
  assign rx_overflow_out     = ovf_q;
endmodule // urx_top

// ===== dv/urx_phy_model.sv
`timescale 1ns/1ps
module urx_phy_model (
  input  wire logic clk_in,
  output logic [15:0] rx_data_out,
  output logic [1:0]  rx_valid_out,
  output logic        rx_active_out,
  output logic        rx_error_out
);
  initial begin
    rx_data_out = 16'h5A5A;
    rx_valid_out = 2'b00;
    rx_active_out = 1'b0;
    rx_error_out = 1'b0;
  end
  // Idle data toggles so no stale word looks valid
  always @(posedge clk_in) if (!rx_active_out) rx_data_out <= ~rx_data_out;
  task automatic send(input int n, input logic fs, input logic [7:0] b, input logic e);
    int k;
    k = 0;
    @(posedge clk_in);
    rx_active_out <= 1'b1;
    while (k < n) begin
      @(posedge clk_in);
      rx_valid_out <= (n - k > 1) ? 2'b11 : 2'b01;
      rx_data_out <= {(n - k > 1) ? b + 8'(k + 1) : ~b, b + 8'(k)};
      rx_error_out <= e && (k + 2 >= n);
      k += 2;
      if (k < n && (fs || k[2])) begin
        @(posedge clk_in);
        rx_valid_out <= 2'b00;
        rx_data_out <= ~rx_data_out;
      end
    end
    @(posedge clk_in);
    rx_active_out <= 1'b0;
    rx_valid_out <= 2'b00;
    rx_error_out <= 1'b0;
    repeat (2) @(posedge clk_in);
  endtask
endmodule // urx_phy_model

// ===== dv/urx_top_checker.sv
`timescale 1ns/1ps
module urx_top_checker (
  input wire logic        clk_in,
  input wire logic        rst_in,
  input wire logic        host_req_valid_in,
  input wire logic        host_read_sel_in,
  input wire logic [1:0]  rx_valid_in,
  input wire logic        rx_active_in,
  input wire logic        rx_error_in,
  input wire logic        host_access_ack_out,
  input wire logic [15:0] host_read_word_out,
  input wire logic        pkt_pending_out,
  input wire logic        rx_overflow_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  ack_follows_req_a: assert property ($rose(host_req_valid_in) |=> host_access_ack_out)
    else $error("ack missing");
  ack_single_a: assert property (host_access_ack_out |=> !host_access_ack_out)
    else $error("ack too long");
  no_rearm_a: assert property (host_access_ack_out ##1 host_req_valid_in [*2] |->
    !host_access_ack_out) else $error("ack without new request");
  rdata_on_ack_a: assert property ($changed(host_read_word_out) |->
    host_access_ack_out && $past(host_read_sel_in)) else $error("read word moved");
  pending_at_end_a: assert property ($rose(pkt_pending_out) |-> !$past(rx_active_in))
    else $error("pending early");
  err_discard_a: assert property (rx_active_in && rx_error_in && !pkt_pending_out
    ##1 !rx_active_in |=> !pkt_pending_out) else $error("bad packet kept");
  ovf_cause_a: assert property ($rose(rx_overflow_out) |->
    $past(rx_active_in && rx_valid_in != 2'b00)) else $error("overflow without word");
  ovf_clear_a: assert property ($fell(rx_overflow_out) |->
    $past(host_access_ack_out && !host_read_sel_in)) else $error("overflow lost");
  cover property (host_access_ack_out && host_read_sel_in);
  cover property ($rose(pkt_pending_out));
  cover property ($rose(rx_overflow_out));
endmodule // urx_top_checker
bind urx_top urx_top_checker i_chk (.clk_in(clk_in), .rst_in(rst_in),
  .host_req_valid_in(host_req_valid_in), .host_read_sel_in(host_read_sel_in),
  .rx_valid_in(rx_valid_in), .rx_active_in(rx_active_in), .rx_error_in(rx_error_in),
  .host_access_ack_out(host_access_ack_out), .host_read_word_out(host_read_word_out),
  .pkt_pending_out(pkt_pending_out), .rx_overflow_out(rx_overflow_out));

// ===== dv/tb_top.sv
`timescale 1ns/1ps
`include "urx_cfg.svh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_mismatch++; \
  $display("ERROR %0t got %h want %h", $time, (a), (b)); end end
module tb_top;
  logic        clk_in, rst_in, req, rs, ack, pend, ovf, ra, re;
  logic [6:0]  ad;
  logic [1:0]  bl, rv;
  logic [15:0] wd, rdw, rx_d;
  logic [16:0] exp_q[$];
  int          n_mismatch, total_checks, cyc;
  integer      seed;
  urx_phy_model i_phy (.clk_in(clk_in), .rx_data_out(rx_d), .rx_valid_out(rv),
    .rx_active_out(ra), .rx_error_out(re));
  urx_top i_dut (.clk_in(clk_in), .rst_in(rst_in), .rx_data_in(rx_d), .rx_valid_in(rv),
    .rx_active_in(ra), .rx_error_in(re), .host_req_valid_in(req), .host_reg_addr_in(ad),
    .host_read_sel_in(rs), .host_byte_lane_en_in(bl), .host_write_word_in(wd),
    .host_access_ack_out(ack), .host_read_word_out(rdw), .pkt_pending_out(pend),
    .rx_overflow_out(ovf));
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  task automatic report_and_stop();
    if (n_mismatch == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic acc(input logic r, input logic [6:0] a, input logic [1:0] be,
                     input logic [15:0] d, input int hold, output logic [15:0] q);
    int t;
    t = 0;
    @(posedge clk_in);
    req <= 1'b1;
    rs <= r;
    ad <= a;
    bl <= be;
    wd <= d;
    do begin
      @(posedge clk_in);
      t++;
    end while (ack !== 1'b1 && t < 40);
    q = rdw;
    repeat (hold) @(posedge clk_in);
    req <= 1'b0;
    rs <= ~r;
    ad <= ~a;
    bl <= 2'b00;
    wd <= ~d;
    if (t >= 40) n_mismatch++;
  endtask
  task automatic drain();
    logic [15:0] q;
    logic [16:0] w;
    `CHK(pend, exp_q.size() > 0)
    acc(1'b1, `URX_IDX_COUNT, 2'b11, 16'h0000, 0, q);
    `CHK(q, 16'(exp_q.size()))
    while (exp_q.size() > 0) begin
      w = exp_q.pop_front();
      acc(1'b1, `URX_IDX_EP_PORT, w[16] ? 2'b01 : 2'b11, 16'h0000, 0, q);
      `CHK(q, w[15:0])
    end
  endtask
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  initial begin
    logic [15:0] q;
    logic [7:0]  b;
    int          n;
    seed = 32'h7fc7d12d;
    cyc = 0;
    rst_in = 1'b1;
    req = 1'b0;
    rs = 1'b1;
    ad = 7'h00;
    bl = 2'b00;
    wd = 16'h0000;
    repeat (10) @(posedge clk_in);
    rst_in <= 1'b0;
    `CHK({ack, rdw, pend, ovf}, 19'h00000)
    for (int i = 1; i < 4; i++) begin
      acc(1'b1, `URX_IDX_CTRL, 2'(i), 16'h0000, 0, q);
      `CHK(q, i[0] ? 16'h0001 : 16'h0000)
    end
    acc(1'b1, 7'h7F, 2'b11, 16'h0000, 2, q);
    `CHK(q, 16'h0000)
    acc(1'b0, `URX_IDX_CTRL, 2'b11, 16'h0000, 0, q);
    i_phy.send(4, 1'b0, 8'h11, 1'b0);
    drain();
    acc(1'b0, `URX_IDX_CTRL, 2'b11, 16'h0001, 0, q);
    for (int i = 0; i < 6; i++) begin
      b = 8'($random(seed));
      n = 1 + 3 * i;
      i_phy.send(n, i[0], b, i == 4);
      for (int k = 0; k < n && i != 4; k += 2)
        exp_q.push_back({n - k == 1, (n - k > 1) ? 8'(b + k + 1) : 8'h00, 8'(b + k)});
      if (i[0]) drain();
    end
    i_phy.send(66, 1'b0, 8'h40, 1'b0);
    `CHK({ovf, pend}, 2'b10)
    acc(1'b1, `URX_IDX_STATUS, 2'b01, 16'h0000, 0, q);
    `CHK(q[2:1], 2'b11)
    acc(1'b0, `URX_IDX_STATUS, 2'b01, 16'h0006, 0, q);
    acc(1'b1, `URX_IDX_STATUS, 2'b11, 16'h0000, 0, q);
    `CHK({ovf, q}, 17'h00000)
    report_and_stop();
  end
endmodule // tb_top
